//--- rtl/ctc_pkg.sv
// package: constants, register map and types of the camera timer/counter
package ctc_pkg;

  localparam int unsigned CLK_HZ = 250000000;
  localparam int unsigned TICK_US = 1;
  localparam int unsigned TICK_CYCLES = (CLK_HZ / 1000000) * TICK_US;

  localparam int unsigned DLY_W = 24;
  localparam int unsigned CNT_W = 32;
  localparam int unsigned SRC_W = 3;
  localparam int unsigned ADDR_W = 8;

  localparam logic [23:0] DELAY_MAX = 24'hffffff;
  localparam logic [23:0] DELAY_RST = 24'h000000;
  localparam logic [23:0] WIDTH_MIN = 24'h000001;
  localparam logic [23:0] WIDTH_RST = 24'h000001;

  // register byte offsets
  localparam logic [7:0] REG_DELAY = 8'h00;
  localparam logic [7:0] REG_WIDTH = 8'h04;
  localparam logic [7:0] REG_PCFG = 8'h08;
  localparam logic [7:0] REG_PSTAT = 8'h0c;
  localparam logic [7:0] REG_TCFG = 8'h10;
  localparam logic [7:0] REG_TCMD = 8'h14;
  localparam logic [7:0] REG_TVAL = 8'h18;

  // field positions in REG_PCFG
  localparam int unsigned PCFG_SRC_LSB = 0;
  localparam int unsigned PCFG_POL_BIT = 4;
  // field positions in REG_TCFG
  localparam int unsigned TCFG_EVT_LSB = 0;
  localparam int unsigned TCFG_EVP_BIT = 4;
  localparam int unsigned TCFG_CLR_LSB = 8;
  localparam int unsigned TCFG_CLP_BIT = 12;
  // REG_TCMD bit 0 is the software clear command
  localparam int unsigned TCMD_CLR_BIT = 0;

  // source codes: 0 off, 1..6 signal inputs, 7 software
  localparam logic [2:0] SRC_OFF = 3'h0;
  localparam logic [2:0] SRC_SOFT = 3'h7;
  localparam int unsigned NUM_SIG = 6;

  localparam logic POL_RISE = 1'b0;
  localparam logic POL_FALL = 1'b1;

  typedef enum logic [1:0] {
    PS_IDLE,
    PS_DELAY,
    PS_ACTIVE
  } ctc_pstate_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ctc_bus_type;

  typedef struct packed {
    logic [SRC_W-1:0] src;
    logic pol;
  } ctc_sel_type;

endpackage

//--- rtl/ctc_edge_pick.sv
// module: source multiplexer with registered edge detection
`timescale 1ns/1ps
module ctc_edge_pick #(
  parameter int unsigned N = 6
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [N-1:0] sig_i,
  input wire logic soft_i,
  input wire ctc_pkg::ctc_sel_type sel_i,
  output logic hit_o
);

  logic [N:0] prev_r;
  logic [N:0] prev_nxt;
  logic [N:0] cur;
  logic hit_r;
  logic hit_nxt;

  // index 0 unused (off); software source is a pulse, not a level, so no edge needed
  always_comb
  begin
    cur = {sig_i, 1'b0};
    prev_nxt = cur;
    hit_nxt = 1'b0;
    if (sel_i.src == ctc_pkg::SRC_SOFT)
    begin
      hit_nxt = soft_i;
    end
    else if (sel_i.src != ctc_pkg::SRC_OFF && int'(sel_i.src) <= N)
    begin
      if (sel_i.pol == ctc_pkg::POL_RISE)
      begin
        hit_nxt = cur[sel_i.src] & ~prev_r[sel_i.src];
      end
      else
      begin
        hit_nxt = ~cur[sel_i.src] & prev_r[sel_i.src];
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      prev_r <= '0;
      hit_r <= 1'b0;
    end
    else
    begin
      prev_r <= prev_nxt;
      hit_r <= hit_nxt;
    end
  end

  assign hit_o = hit_r;

endmodule

//--- rtl/ctc_top.sv
// module: delay-and-pulse timer plus event counter with register port
`timescale 1ns/1ps
module ctc_top #(
  parameter int unsigned NSIG = ctc_pkg::NUM_SIG,
  parameter int unsigned TICK_CYC = ctc_pkg::TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [NSIG-1:0] sig_i,
  input wire logic [ctc_pkg::ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic pulse_active_out_o
);

  ctc_pkg::ctc_bus_type bus;
  logic [23:0] pulse_delay_us_r;
  logic [23:0] pulse_delay_us_nxt;
  logic [23:0] pulse_width_us_r;
  logic [23:0] pulse_width_us_nxt;
  ctc_pkg::ctc_sel_type pulse_start_r;
  ctc_pkg::ctc_sel_type pulse_start_nxt;
  ctc_pkg::ctc_sel_type tally_event_r;
  ctc_pkg::ctc_sel_type tally_event_nxt;
  ctc_pkg::ctc_sel_type tally_clear_r;
  ctc_pkg::ctc_sel_type tally_clear_nxt;
  logic soft_clr_r;
  logic soft_clr_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  ctc_pkg::ctc_pstate_type pst_r;
  ctc_pkg::ctc_pstate_type pst_nxt;
  logic [7:0] tick_cnt_r;
  logic [7:0] tick_cnt_nxt;
  logic tick_r;
  logic tick_nxt;
  logic [23:0] us_cnt_r;
  logic [23:0] us_cnt_nxt;
  logic [23:0] width_lat_r;
  logic [23:0] width_lat_nxt;
  logic active_r;
  logic active_nxt;
  logic [ctc_pkg::CNT_W-1:0] tally_r;
  logic [ctc_pkg::CNT_W-1:0] tally_nxt;

  logic start_hit;
  logic event_hit;
  logic clear_hit;

  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  function automatic ctc_pkg::ctc_sel_type sel_of(input logic [31:0] d, input int unsigned lsb,
                                                  input int unsigned pb);
    ctc_pkg::ctc_sel_type s;
    s.src = d[lsb +: ctc_pkg::SRC_W];
    s.pol = d[pb];
    return s;
  endfunction

  function automatic logic [31:0] sel_word(input ctc_pkg::ctc_sel_type s, input int unsigned lsb,
                                           input int unsigned pb);
    logic [31:0] w;
    w = '0;
    w[lsb +: ctc_pkg::SRC_W] = s.src;
    w[pb] = s.pol;
    return w;
  endfunction

  // register writes and reads
  always_comb
  begin
    pulse_delay_us_nxt = pulse_delay_us_r;
    pulse_width_us_nxt = pulse_width_us_r;
    pulse_start_nxt = pulse_start_r;
    tally_event_nxt = tally_event_r;
    tally_clear_nxt = tally_clear_r;
    soft_clr_nxt = 1'b0;
    rdata_nxt = '0;
    if (bus.wr)
    begin
      case (bus.addr)
        ctc_pkg::REG_DELAY: pulse_delay_us_nxt = bus.wdata[23:0];
        ctc_pkg::REG_WIDTH:
        begin
          // zero width is out of range; clamp to the minimum rather than a stuck pulse
          if (bus.wdata[23:0] < ctc_pkg::WIDTH_MIN)
          begin
            pulse_width_us_nxt = ctc_pkg::WIDTH_MIN;
          end
          else
          begin
            pulse_width_us_nxt = bus.wdata[23:0];
          end
        end
        ctc_pkg::REG_PCFG: pulse_start_nxt = sel_of(bus.wdata, ctc_pkg::PCFG_SRC_LSB,
                                                    ctc_pkg::PCFG_POL_BIT);
        ctc_pkg::REG_TCFG:
        begin
          tally_event_nxt = sel_of(bus.wdata, ctc_pkg::TCFG_EVT_LSB,
                                   ctc_pkg::TCFG_EVP_BIT);
          tally_clear_nxt = sel_of(bus.wdata, ctc_pkg::TCFG_CLR_LSB,
                                   ctc_pkg::TCFG_CLP_BIT);
        end
        ctc_pkg::REG_TCMD: soft_clr_nxt = bus.wdata[ctc_pkg::TCMD_CLR_BIT];
        default: soft_clr_nxt = 1'b0;
      endcase
    end
    if (bus.rd)
    begin
      case (bus.addr)
        ctc_pkg::REG_DELAY: rdata_nxt = {8'h00, pulse_delay_us_r};
        ctc_pkg::REG_WIDTH: rdata_nxt = {8'h00, pulse_width_us_r};
        ctc_pkg::REG_PCFG: rdata_nxt = sel_word(pulse_start_r, ctc_pkg::PCFG_SRC_LSB,
                                                ctc_pkg::PCFG_POL_BIT);
        ctc_pkg::REG_PSTAT: rdata_nxt = {6'h00, pst_r, us_cnt_r};
        ctc_pkg::REG_TCFG: rdata_nxt = sel_word(tally_event_r, ctc_pkg::TCFG_EVT_LSB,
                                                ctc_pkg::TCFG_EVP_BIT)
                                     | sel_word(tally_clear_r, ctc_pkg::TCFG_CLR_LSB,
                                                ctc_pkg::TCFG_CLP_BIT);
        ctc_pkg::REG_TVAL: rdata_nxt = tally_r;
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pulse_delay_us_r <= ctc_pkg::DELAY_RST;
      pulse_width_us_r <= ctc_pkg::WIDTH_RST;
      pulse_start_r <= '{src: ctc_pkg::SRC_OFF, pol: ctc_pkg::POL_RISE};
      tally_event_r <= '{src: ctc_pkg::SRC_OFF, pol: ctc_pkg::POL_RISE};
      tally_clear_r <= '{src: ctc_pkg::SRC_OFF, pol: ctc_pkg::POL_RISE};
      soft_clr_r <= 1'b0;
      rdata_r <= '0;
    end
    else
    begin
      pulse_delay_us_r <= pulse_delay_us_nxt;
      pulse_width_us_r <= pulse_width_us_nxt;
      pulse_start_r <= pulse_start_nxt;
      tally_event_r <= tally_event_nxt;
      tally_clear_r <= tally_clear_nxt;
      soft_clr_r <= soft_clr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // software strobe reaches only the clear selector, and acts only when it selects the software source
  ctc_edge_pick #(.N(NSIG)) u_start (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .sig_i(sig_i),
    .soft_i(1'b0),
    .sel_i(pulse_start_r),
    .hit_o(start_hit)
  );

  ctc_edge_pick #(.N(NSIG)) u_event (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .sig_i(sig_i),
    .soft_i(1'b0),
    .sel_i(tally_event_r),
    .hit_o(event_hit)
  );

  ctc_edge_pick #(.N(NSIG)) u_clear (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .sig_i(sig_i),
    .soft_i(soft_clr_r),
    .sel_i(tally_clear_r),
    .hit_o(clear_hit)
  );

  // pulse timer; tick phase restarts at the edge so delay is exact to one clock
  always_comb
  begin
    pst_nxt = pst_r;
    us_cnt_nxt = us_cnt_r;
    width_lat_nxt = width_lat_r;
    tick_nxt = 1'b0;
    tick_cnt_nxt = tick_cnt_r + 8'h01;
    if (tick_cnt_r == 8'(TICK_CYC - 1))
    begin
      tick_cnt_nxt = 8'h00;
      tick_nxt = 1'b1;
    end
    case (pst_r)
      ctc_pkg::PS_IDLE:
      begin
        if (start_hit)
        begin
          tick_cnt_nxt = 8'h00;
          tick_nxt = 1'b0;
          width_lat_nxt = pulse_width_us_r;
          us_cnt_nxt = pulse_delay_us_r;
          // zero delay goes straight to the active phase
          pst_nxt = (pulse_delay_us_r == ctc_pkg::DELAY_RST) ? ctc_pkg::PS_ACTIVE
                                                             : ctc_pkg::PS_DELAY;
          if (pulse_delay_us_r == ctc_pkg::DELAY_RST)
          begin
            // active starts one cycle sooner here, so the tick phase starts one step on;
            // without it the pulse would run one clock longer than the width
            tick_cnt_nxt = 8'h01;
            us_cnt_nxt = pulse_width_us_r;
          end
        end
      end
      ctc_pkg::PS_DELAY:
      begin
        if (tick_r)
        begin
          us_cnt_nxt = us_cnt_r - 24'h000001;
          if (us_cnt_r == 24'h000001)
          begin
            us_cnt_nxt = width_lat_r;
            pst_nxt = ctc_pkg::PS_ACTIVE;
          end
        end
      end
      ctc_pkg::PS_ACTIVE:
      begin
        if (tick_r)
        begin
          us_cnt_nxt = us_cnt_r - 24'h000001;
          if (us_cnt_r == 24'h000001)
          begin
            us_cnt_nxt = 24'h000000;
            pst_nxt = ctc_pkg::PS_IDLE;
          end
        end
      end
      default: pst_nxt = ctc_pkg::PS_IDLE;
    endcase
    active_nxt = (pst_nxt == ctc_pkg::PS_ACTIVE);
  end

  // tally counter; clear takes priority over an event in the same cycle
  always_comb
  begin
    tally_nxt = tally_r;
    if (clear_hit)
    begin
      tally_nxt = '0;
    end
    else if (event_hit)
    begin
      tally_nxt = tally_r + 32'h00000001;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pst_r <= ctc_pkg::PS_IDLE;
      us_cnt_r <= '0;
      width_lat_r <= ctc_pkg::WIDTH_RST;
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
      active_r <= 1'b0;
      tally_r <= '0;
    end
    else
    begin
      pst_r <= pst_nxt;
      us_cnt_r <= us_cnt_nxt;
      width_lat_r <= width_lat_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      tick_r <= tick_nxt;
      active_r <= active_nxt;
      tally_r <= tally_nxt;
    end
  end

  assign rdata_o = rdata_r;
  assign pulse_active_out_o = active_r;

  a_clear_wins: assert property (@(posedge clk_i) disable iff (!resetn_i)
    clear_hit |=> tally_r == '0) else $error("count not zero after clear");
  a_event_incr: assert property (@(posedge clk_i) disable iff (!resetn_i)
    event_hit && !clear_hit |=> tally_r == $past(tally_r) + 32'h00000001)
    else $error("count did not step by one");
  a_count_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !event_hit && !clear_hit |=> tally_r == $past(tally_r))
    else $error("count moved without event");
  // a steady line cannot make an edge, so any clear after the strobe came from the strobe
  a_soft_gated: assert property (@(posedge clk_i) disable iff (!resetn_i)
    soft_clr_r && tally_clear_r.src != ctc_pkg::SRC_SOFT && sig_i == $past(sig_i)
    |=> !clear_hit) else $error("software clear acted with wrong source");
  a_off_idle: assert property (@(posedge clk_i) disable iff (!resetn_i)
    pulse_start_r.src == ctc_pkg::SRC_OFF && $past(pulse_start_r.src) == ctc_pkg::SRC_OFF
    |-> !start_hit) else $error("timer started with source off");
  a_start_leaves: assert property (@(posedge clk_i) disable iff (!resetn_i)
    start_hit && pst_r == ctc_pkg::PS_IDLE |=> pst_r != ctc_pkg::PS_IDLE)
    else $error("timer ignored start edge");
  a_out_state: assert property (@(posedge clk_i) disable iff (!resetn_i)
    pulse_active_out_o == (pst_r == ctc_pkg::PS_ACTIVE) && (!pulse_active_out_o || us_cnt_r != '0))
    else $error("output disagrees with timer state");
  a_width_load: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(pulse_active_out_o) |-> us_cnt_r == width_lat_r)
    else $error("pulse width not loaded at start");
  a_zero_delay: assert property (@(posedge clk_i) disable iff (!resetn_i)
    start_hit && pst_r == ctc_pkg::PS_IDLE && pulse_delay_us_r == '0 |=> pulse_active_out_o)
    else $error("zero delay did not activate at once");
  a_tick_spacing: assert property (@(posedge clk_i) disable iff (!resetn_i)
    tick_r |=> !tick_r) else $error("tick not isolated");
  a_width_min: assert property (@(posedge clk_i) disable iff (!resetn_i)
    pulse_width_us_r != '0) else $error("width fell below minimum");
  a_read_tally: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rd_i && addr_i == ctc_pkg::REG_TVAL |=> rdata_o == $past(tally_r))
    else $error("count readback wrong");
  a_read_state: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rd_i && addr_i == ctc_pkg::REG_PSTAT |=> rdata_o[23:0] == $past(us_cnt_r))
    else $error("timer readback wrong");

  c_pulse_done: cover property (@(posedge clk_i) disable iff (!resetn_i)
    pulse_active_out_o ##1 !pulse_active_out_o);
  c_delay_phase: cover property (@(posedge clk_i) disable iff (!resetn_i)
    pst_r == ctc_pkg::PS_DELAY ##1 pst_r == ctc_pkg::PS_ACTIVE);
  c_clear_event: cover property (@(posedge clk_i) disable iff (!resetn_i)
    clear_hit && event_hit);
  c_soft_clear: cover property (@(posedge clk_i) disable iff (!resetn_i)
    soft_clr_r && tally_clear_r.src == ctc_pkg::SRC_SOFT);
  c_zero_start: cover property (@(posedge clk_i) disable iff (!resetn_i)
    start_hit && pst_r == ctc_pkg::PS_IDLE && pulse_delay_us_r == '0);

endmodule

//--- bench/ctc_sig_model.sv
// partner model: camera line levels and exposure-active signal into the block
`timescale 1ns/1ps
module ctc_sig_model #(
  parameter int unsigned EXP_CYC = 12
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [4:0] lvl_i,
  input wire logic exp_go_i,
  output logic [5:0] sig_o
);
  logic [4:0] lvl_r;
  logic [15:0] exp_cnt_r;
  // lines pass a register, as real input synchronisers would, so edges land one cycle late
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      lvl_r <= 5'h00;
      exp_cnt_r <= 16'h0000;
    end
    else
    begin
      lvl_r <= lvl_i;
      if (exp_go_i)
        exp_cnt_r <= 16'(EXP_CYC); // exposure interval the host lines the pulse up with
      else if (exp_cnt_r != 16'h0000)
        exp_cnt_r <= exp_cnt_r - 16'h0001;
    end
  end
  assign sig_o = {exp_cnt_r != 16'h0000, lvl_r};
endmodule

//--- bench/testbench.sv
// testbench: register-port tests of the pulse timer and event counter
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      err_total++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g); \
    end \
  end
module testbench;
  localparam int unsigned TC = 4;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h00000000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [4:0] lvl = 5'h00;
  logic exp_go = 1'b0;
  logic [5:0] sig;
  logic [31:0] rdata_o;
  logic pulse_active_out_o;
  logic [31:0] d;
  int err_total = 0;
  int samples_checked = 0;
  always #2 clk_i = ~clk_i;
  ctc_sig_model #(.EXP_CYC(12)) i_ctc_sig_model (.clk_i(clk_i), .resetn_i(resetn_i),
    .lvl_i(lvl), .exp_go_i(exp_go), .sig_o(sig));
  // short tick keeps microsecond counts cheap in simulation
  ctc_top #(.TICK_CYC(TC)) i_ctc_top (.clk_i(clk_i), .resetn_i(resetn_i), .sig_i(sig),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .pulse_active_out_o(pulse_active_out_o));
  task automatic print_verdict();
    if (err_total == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask
  task automatic chkrd(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    `CHK(nm, e, v)
  endtask
  task automatic setl(input logic [4:0] v);
    @(posedge clk_i);
    lvl <= v;
  endtask
  task automatic fire();
    @(posedge clk_i);
    exp_go <= 1'b1;
    @(posedge clk_i);
    exp_go <= 1'b0;
  endtask
  task automatic src(input int k);
    if (k == 6)
    begin
      fire();
      cyc(16);
    end
    else
    begin
      setl(5'(1 << (k - 1)));
      setl(5'h00);
      cyc(4);
    end
  endtask
  task automatic quiet(input int k);
    int n;
    n = 0;
    repeat (k)
    begin
      @(posedge clk_i);
      #1;
      if (pulse_active_out_o !== 1'b0)
        n++;
    end
    `CHK("pulse idle", 0, n)
  endtask
  task automatic waitp(input logic v);
    int t;
    t = 0;
    while (pulse_active_out_o !== v && t < 400)
    begin
      @(posedge clk_i);
      #1;
      t++;
    end
    if (t >= 400)
    begin
      `CHK("pulse wait", 1'b1, 1'b0)
      print_verdict();
    end
  endtask
  // limitation: start is judged in a window, though the tick phase restarts at the edge
  task automatic run_pulse(input int lo, input int hi, input int wid);
    int t;
    int w;
    t = 0;
    w = 0;
    while (pulse_active_out_o !== 1'b1 && t < 400)
    begin
      @(posedge clk_i);
      #1;
      t++;
    end
    while (pulse_active_out_o === 1'b1 && w < 400)
    begin
      @(posedge clk_i);
      #1;
      w++;
    end
    `CHK("pulse start", 1'b1, t >= lo && t <= hi)
    `CHK("pulse width", wid, w)
    if (t >= 400 || w >= 400)
      print_verdict();
  endtask
  initial
  begin
    cyc(16);
    resetn_i <= 1'b1;
    chkrd("delay", ctc_pkg::REG_DELAY, 32'h0);
    chkrd("width", ctc_pkg::REG_WIDTH, 32'h1);
    chkrd("pcfg", ctc_pkg::REG_PCFG, 32'h0);
    chkrd("tcfg", ctc_pkg::REG_TCFG, 32'h0);
    chkrd("count", ctc_pkg::REG_TVAL, 32'h0);
    chkrd("unmapped", 8'h20, 32'h0);
    wr(ctc_pkg::REG_WIDTH, 32'h0);
    chkrd("width min", ctc_pkg::REG_WIDTH, 32'h1);
    wr(ctc_pkg::REG_DELAY, 32'hffffff);
    chkrd("delay max", ctc_pkg::REG_DELAY, 32'hffffff);
    setl(5'h01);
    quiet(40);
    setl(5'h00);
    wr(ctc_pkg::REG_DELAY, 32'h3);
    wr(ctc_pkg::REG_WIDTH, 32'h3);
    wr(ctc_pkg::REG_PCFG, 32'h1);
    setl(5'h01);
    run_pulse(3 * TC + 1, 3 * TC + TC + 6, 3 * TC);
    setl(5'h00);
    wr(ctc_pkg::REG_DELAY, 32'h5);
    wr(ctc_pkg::REG_WIDTH, 32'h2);
    setl(5'h01);
    cyc(3);
    rd(ctc_pkg::REG_PSTAT, d);
    `CHK("state delay", 2'h1, d[25:24])
    waitp(1'b1);
    rd(ctc_pkg::REG_PSTAT, d);
    `CHK("state active", 2'h2, d[25:24])
    waitp(1'b0);
    chkrd("state idle", ctc_pkg::REG_PSTAT, 32'h0);
    setl(5'h00);
    wr(ctc_pkg::REG_DELAY, 32'h1);
    wr(ctc_pkg::REG_WIDTH, 32'h1);
    wr(ctc_pkg::REG_PCFG, 32'h11);
    setl(5'h01);
    quiet(20);
    setl(5'h00);
    run_pulse(TC + 1, 2 * TC + 6, TC);
    wr(ctc_pkg::REG_DELAY, 32'h0);
    wr(ctc_pkg::REG_WIDTH, 32'h3);
    wr(ctc_pkg::REG_PCFG, 32'h6);
    fire();
    // width of three ticks matches the twelve-cycle exposure interval of the model
    run_pulse(1, TC + 6, 12);
    for (int k = 1; k <= 6; k++)
    begin
      wr(ctc_pkg::REG_TCFG, 32'h700 | 32'(k));
      wr(ctc_pkg::REG_TCMD, 32'h1);
      src(k);
      src(k);
      src(k == 1 ? 2 : 1);
      chkrd("count per source", ctc_pkg::REG_TVAL, 32'h2);
    end
    // no clear since the last loop pass, so its two events stay in the count
    wr(ctc_pkg::REG_TCFG, 32'h0301);
    repeat (3) src(1);
    chkrd("count five", ctc_pkg::REG_TVAL, 32'h5);
    setl(5'h04);
    cyc(4);
    chkrd("count cleared", ctc_pkg::REG_TVAL, 32'h0);
    wr(ctc_pkg::REG_TCFG, 32'h1301);
    src(1);
    setl(5'h00);
    cyc(4);
    chkrd("falling clear", ctc_pkg::REG_TVAL, 32'h0);
    src(1);
    setl(5'h04);
    cyc(4);
    chkrd("rising kept", ctc_pkg::REG_TVAL, 32'h1);
    wr(ctc_pkg::REG_TCMD, 32'h1);
    cyc(4);
    chkrd("soft ignored", ctc_pkg::REG_TVAL, 32'h1);
    wr(ctc_pkg::REG_TCFG, 32'h0201);
    setl(5'h07);
    cyc(4);
    chkrd("clear wins", ctc_pkg::REG_TVAL, 32'h0);
    setl(5'h00);
    cyc(4);
    print_verdict();
  end
endmodule
